// ===== core/bcdc_pkg.sv
// Shared constants and types for the BCD up/down counter stage and its controller
package bcdc_pkg;
    localparam int DIGIT_W = 4;
    localparam logic [3:0] DIGIT_MIN = 4'h0;
    localparam logic [3:0] DIGIT_MAX = 4'h9;
    localparam logic [3:0] DIGIT_ONE = 4'h1;
    localparam logic DIR_UP = 1'b1;
    localparam logic DIR_DOWN = 1'b0;
    // Controller register map (word offsets on the plain port)
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] PRESET_OFS = 4'h1;
    localparam logic [3:0] STATUS_OFS = 4'h2;
    localparam logic [3:0] CMD_OFS = 4'h3;
    // Control register fields
    localparam int CTRL_DIR_BIT = 0;
    localparam int CTRL_RUN_BIT = 1;
    // Command register fields
    localparam int CMD_LOAD_BIT = 0;
    localparam int CMD_CLEAR_BIT = 1;
    localparam logic [31:0] REG_ZERO = 32'h0000_0000;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    typedef enum logic [1:0] {
        BCDC_IDLE = 2'b00,
        BCDC_LOAD = 2'b01,
        BCDC_CLEAR = 2'b10
    } bcdc_cmd_state_type;
endpackage : bcdc_pkg

// ===== core/bcdc_link_if.sv
// Cascade link between one counter stage and the logic that drives it
`timescale 1ns/10ps
`default_nettype none
interface bcdc_link_if;
    logic preset_load_strobe;
    logic clear;
    logic up_down;
    logic carry_in_n;
    logic [3:0] preset;
    logic [3:0] count;
    logic carry_out_n;
    modport stage (
        input preset_load_strobe, clear, up_down, carry_in_n, preset,
        output count, carry_out_n
    );
    modport ctrl (
        output preset_load_strobe, clear, up_down, carry_in_n, preset,
        input count, carry_out_n
    );
endinterface : bcdc_link_if
`default_nettype wire

// ===== core/bcdc_stage.sv
// One decade of the synchronous BCD up/down counter
//
// Contract
// - Load strobe high copies preset into count
// - Load acts at once, blocks clock counting
// - Clear high forces count low, blocks clock
// - Enable input active low; high holds count
// - Enabled rising edge steps count by one
// - Direction high counts up, low down
// - Count output is BCD, bit0 least significant
// - Terminal count active low, cascade enable
// - Terminal count low one clock at limit
// - Ten states per decade, carry every ten
// - After load, counting resumes from preset
// - Partner releases load and clear before edge
// - Each stage enabled by lower terminal count
// - Divider: down mode, BCD ratio up to 99
// - Partner avoids divide ratio of zero
// - Terminal count decode per direction and enable
//
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module bcdc_stage (
    input wire logic clk_sys,
    input wire logic reset,
    bcdc_link_if.stage link
);
    import bcdc_pkg::*;

    // What the stage does at the coming edge, weakest first
    typedef enum logic [1:0] {
        BCDC_ACT_HOLD = 2'b00,
        BCDC_ACT_STEP = 2'b01,
        BCDC_ACT_LOAD = 2'b10,
        BCDC_ACT_CLEAR = 2'b11
    } bcdc_action_type;

    // Up step; codes at or past nine fold to zero so a stray code cannot stick
    function automatic logic [3:0] bcd_inc(input logic [3:0] value);
        logic [3:0] result;
        if (value >= DIGIT_MAX) begin
            result = DIGIT_MIN;
        end else begin
            result = value + DIGIT_ONE;
        end
        return result;
    endfunction : bcd_inc

    // Down step with the zero to nine wrap
    function automatic logic [3:0] bcd_dec(input logic [3:0] value);
        logic [3:0] result;
        if (value == DIGIT_MIN) begin
            result = DIGIT_MAX;
        end else begin
            result = value - DIGIT_ONE;
        end
        return result;
    endfunction : bcd_dec

    // Limit digit for the direction: nine is the only BCD code with both end bits set
    function automatic logic term_reached(
        input logic [3:0] value,
        input logic dir
    );
        logic reached;
        case (dir)
            DIR_UP: begin
                reached = value[0] & value[DIGIT_W - 1];
            end
            default: begin
                reached = (value == DIGIT_MIN);
            end
        endcase
        return reached;
    endfunction : term_reached

    // Count register and its next value
    logic [3:0] count_reg;
    logic [3:0] count_next;
    logic [3:0] shown;
    logic carry_n_word;
    bcdc_action_type action;

    // Named pins of the digit
    wire logic preset_bit0;
    wire logic preset_bit1;
    wire logic preset_bit2;
    wire logic preset_bit3;
    wire logic [3:0] preset_word;
    wire logic count_bit0;
    wire logic count_bit1;
    wire logic count_bit2;
    wire logic count_bit3;
    wire logic [3:0] count_word;

    wire logic count_en;
    wire logic [3:0] step_up;
    wire logic [3:0] step_down;
    wire logic [3:0] stepped;
    wire logic term_hit;

    // Split the preset digit onto its named inputs
    assign preset_bit0 = link.preset[0];
    assign preset_bit1 = link.preset[1];
    assign preset_bit2 = link.preset[2];
    assign preset_bit3 = link.preset[3];
    assign preset_word = {preset_bit3, preset_bit2, preset_bit1, preset_bit0};

    assign count_en = ~link.carry_in_n & ~link.clear & ~link.preset_load_strobe;
    assign step_up = bcd_inc(count_reg);
    assign step_down = bcd_dec(count_reg);
    assign stepped = (link.up_down == DIR_UP) ? step_up : step_down;

    // clear over load over count
    // Stepping only when neither override is up keeps the edge from fighting the mux
    always_comb begin
        if (link.clear) begin
            action = BCDC_ACT_CLEAR;
        end else if (link.preset_load_strobe) begin
            action = BCDC_ACT_LOAD;
        end else if (count_en) begin
            action = BCDC_ACT_STEP;
        end else begin
            action = BCDC_ACT_HOLD;
        end
    end

    // ten states, one step per enabled edge
    always_comb begin
        case (action)
            BCDC_ACT_CLEAR: begin
                count_next = DIGIT_MIN;
            end
            BCDC_ACT_LOAD: begin
                count_next = preset_word;
            end
            BCDC_ACT_STEP: begin
                count_next = stepped;
            end
            default: begin
                count_next = count_reg;
            end
        endcase
    end

    // a load leaves the preset in the register for later edges
    // The block reset is synchronous; load and clear reach the register through count_next at the edge and the pins through the output mux
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            count_reg <= DIGIT_MIN;
        end else begin
            count_reg <= count_next;
        end
    end

    // load and clear act without waiting for an edge
    // clear shows low at once
    // The pins follow the overrides within the cycle; the register catches up at the edge
    always_comb begin
        case (action)
            BCDC_ACT_CLEAR: begin
                shown = DIGIT_MIN;
            end
            BCDC_ACT_LOAD: begin
                shown = preset_word;
            end
            default: begin
                shown = count_reg;
            end
        endcase
    end

    for (genvar i = 0; i < DIGIT_W; i++) begin : g_count_bit
        assign count_word[i] = shown[i];
    end
    assign count_bit0 = count_word[0];
    assign count_bit1 = count_word[1];
    assign count_bit2 = count_word[2];
    assign count_bit3 = count_word[3];
    assign link.count = count_word;

    assign term_hit = term_reached({count_bit3, count_bit2, count_bit1, count_bit0}, link.up_down);
    // active low, decoded from the shown count
    // low one full cycle at the limit
    always_comb begin
        if (link.carry_in_n) begin
            carry_n_word = 1'b1;
        end else if (term_hit) begin
            carry_n_word = 1'b0;
        end else begin
            carry_n_word = 1'b1;
        end
    end
    assign link.carry_out_n = carry_n_word;
endmodule : bcdc_stage
`default_nettype wire

// ===== core/bcdc_ctrl.sv
// Controlling logic that drives one counter stage from a register port
`timescale 1ns/10ps
`default_nettype none
module bcdc_ctrl (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [31:0] rdata,
    bcdc_link_if.ctrl link
);
    import bcdc_pkg::*;

    logic [3:0] ctrl_reg;
    logic [3:0] preset_reg;
    bcdc_cmd_state_type state_reg;
    bcdc_cmd_state_type state_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    wire logic wr_ctrl;
    wire logic wr_preset;
    wire logic wr_cmd;
    wire logic [3:0] preset_digit;

    // A stray non-BCD write saturates at nine rather than feeding the stage an illegal code
    assign preset_digit = (wdata[3:0] > DIGIT_MAX) ? DIGIT_MAX : wdata[3:0];
    assign wr_ctrl = wr_stb & (addr == CTRL_OFS);
    assign wr_preset = wr_stb & (addr == PRESET_OFS);
    assign wr_cmd = wr_stb & (addr == CMD_OFS);

    // Clear has precedence so a double command never leaves a stale load
    always_comb begin
        case (state_reg)
            BCDC_IDLE: begin
                if (wr_cmd & wdata[CMD_CLEAR_BIT]) begin
                    state_next = BCDC_CLEAR;
                // zero ratio is software's to avoid
                end else if (wr_cmd & wdata[CMD_LOAD_BIT]) begin
                    state_next = BCDC_LOAD;
                end else begin
                    state_next = BCDC_IDLE;
                end
            end
            default: state_next = BCDC_IDLE;
        endcase
    end

    always_comb begin
        case (addr)
            CTRL_OFS: rdata_next = {28'h0000000, ctrl_reg};
            PRESET_OFS: rdata_next = {28'h0000000, preset_reg};
            STATUS_OFS: rdata_next = {27'h0000000, ~link.carry_out_n, link.count};
            default: rdata_next = REG_ZERO;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ctrl_reg <= CTRL_RESET;
            preset_reg <= DIGIT_MIN;
            state_reg <= BCDC_IDLE;
            rdata_reg <= REG_ZERO;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= wdata[3:0];
            end
            if (wr_preset) begin
                preset_reg <= preset_digit;
            end
            state_reg <= state_next;
            rdata_reg <= rd_stb ? rdata_next : REG_ZERO;
        end
    end

    assign rdata = rdata_reg;
    assign link.preset_load_strobe = (state_reg == BCDC_LOAD);
    assign link.clear = (state_reg == BCDC_CLEAR);
    assign link.up_down = ctrl_reg[CTRL_DIR_BIT];
    // run bit stands in for lower carry
    assign link.carry_in_n = ~ctrl_reg[CTRL_RUN_BIT];
    assign link.preset = preset_reg;
endmodule : bcdc_ctrl
`default_nettype wire

// ===== sim/bcdc_chk.sv
// Assertion checker for the counter stage link
`timescale 1ns/10ps
`default_nettype none
module bcdc_chk (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic preset_load_strobe,
    input wire logic clear,
    input wire logic up_down,
    input wire logic carry_in_n,
    input wire logic [3:0] preset,
    input wire logic [3:0] count,
    input wire logic carry_out_n
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    // Load and clear override the shown count, so stepping is judged only when neither is up
    wire logic quiet = !clear && !preset_load_strobe;
    property p_clr; clear |-> count == 4'h0; endproperty
    a_clr: assert property (p_clr) else $error("clear ignored");
    property p_ld; preset_load_strobe && !clear |-> count == preset; endproperty
    a_ld: assert property (p_ld) else $error("preset not loaded");
    property p_hold; quiet && carry_in_n ##1 quiet |-> $stable(count); endproperty
    a_hold: assert property (p_hold) else $error("count moved");
    property p_up; quiet && !carry_in_n && up_down ##1 quiet
        |-> count == ($past(count) == 4'h9 ? 4'h0 : $past(count) + 4'h1); endproperty
    a_up: assert property (p_up) else $error("bad up step");
    property p_dn; quiet && !carry_in_n && !up_down ##1 quiet
        |-> count == ($past(count) == 4'h0 ? 4'h9 : $past(count) - 4'h1); endproperty
    a_dn: assert property (p_dn) else $error("bad down step");
    property p_tc; carry_out_n == !(!carry_in_n && (up_down ? count[0] && count[3] : count == 4'h0));
    endproperty
    a_tc: assert property (p_tc) else $error("bad terminal count");
    property p_one; quiet && !carry_in_n && !carry_out_n ##1 quiet && !carry_in_n |-> carry_out_n;
    endproperty
    a_one: assert property (p_one) else $error("terminal count too long");
    property p_bcd; count <= 4'h9; endproperty
    a_bcd: assert property (p_bcd) else $error("count not BCD");
endmodule : bcdc_chk
`default_nettype wire

// ===== sim/bcd_up_down_counter_tb.sv
// Testbench: controller and stage joined by the link
`timescale 1ns/10ps
`default_nettype none
module bcd_up_down_counter_tb;
    import bcdc_pkg::*;
    logic clk_sys, reset, wr_stb, rd_stb;
    logic vld = 1'b0;
    logic [3:0] addr, d, m, ev;
    logic [31:0] wdata, rdata;
    logic [3:0] q[$];
    int err_total = 0;
    int samples_checked = 0;
    bcdc_link_if lk();
    bcdc_ctrl u_bcdc_ctrl (.clk_sys(clk_sys), .reset(reset), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .link(lk));
    bcdc_stage u_bcdc_stage (.clk_sys(clk_sys), .reset(reset), .link(lk));
    bcdc_chk u_bcdc_chk (.clk_sys(clk_sys), .reset(reset), .preset_load_strobe(lk.preset_load_strobe),
        .clear(lk.clear), .up_down(lk.up_down), .carry_in_n(lk.carry_in_n), .preset(lk.preset),
        .count(lk.count), .carry_out_n(lk.carry_out_n));
    // Reference count built from the link controls
    always @(posedge clk_sys)
        if (reset || lk.clear) m <= 4'h0;
        else if (lk.preset_load_strobe) m <= lk.preset;
        else if (!lk.carry_in_n)
            m <= lk.up_down ? (m == 4'h9 ? 4'h0 : m + 4'h1) : (m == 4'h0 ? 4'h9 : m - 4'h1);
    always @(posedge clk_sys) vld <= rd_stb;
    always @(negedge clk_sys)
        if (vld) begin
            samples_checked++;
            ev = q.pop_front();
            if (rdata[3:0] !== ev) begin
                err_total++;
                $display("[ERR] rdata exp %h got %h", ev, rdata[3:0]);
            end
        end
    task automatic op(input logic w, input logic [3:0] a, input logic [31:0] dt);
        @(posedge clk_sys);
        addr <= a;
        wdata <= dt;
        wr_stb <= w;
        rd_stb <= !w;
        @(posedge clk_sys);
        wr_stb <= 1'b0;
        rd_stb <= 1'b0;
    endtask : op
    task automatic rd(input logic [3:0] a, input logic [3:0] e);
        q.push_back(e);
        op(1'b0, a, 32'h0);
    endtask : rd
    task automatic conclude();
        if (err_total == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : conclude
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        #100000;
        err_total++;
        conclude();
    end
    initial begin
        void'($urandom(30798));
        {reset, wr_stb, rd_stb, addr, wdata} = {3'b100, 4'h0, 32'h0};
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        rd(STATUS_OFS, 4'h0);
        rd(4'hf, 4'h0);
        for (int i = 0; i < 12; i++) begin
            d = 4'($urandom % 10);
            op(1'b1, PRESET_OFS, {28'h0, d});
            op(1'b1, CMD_OFS, 32'h1);
            rd(STATUS_OFS, d);
            op(1'b1, CTRL_OFS, {30'h0, 1'b1, i[0]});
            repeat ($urandom % 25) @(posedge clk_sys);
            op(1'b1, CTRL_OFS, 32'h0);
            // Let the reference settle past the stop edge
            #1;
            rd(STATUS_OFS, m);
            op(1'b1, CMD_OFS, i[1] ? 32'h3 : 32'h2);
            rd(STATUS_OFS, 4'h0);
            rd(CMD_OFS, 4'h0);
        end
        repeat (3) @(posedge clk_sys);
        conclude();
    end
endmodule : bcd_up_down_counter_tb
`default_nettype wire
